// ### logic/thermal_stage_pkg.sv
package thermal_stage_pkg;
  // thermal capacity and levels in 0.1 % units
  localparam int CAP_W = 11;
  localparam logic [10:0] ALARM1_LEVEL_RST = 11'h190;
  localparam logic [10:0] ALARM2_LEVEL_RST = 11'h190;
  localparam logic [10:0] INHIBIT_LEVEL_RST = 11'h320;
  localparam logic [10:0] TRIP_LEVEL_RST = 11'h3E8;
  // trip delay in 5 ms steps, 0 .. 3600 s
  localparam int DELAY_W = 20;
  localparam logic [19:0] TRIP_DELAY_RST = 20'h00000;
  localparam int DELAY_STEP_US = 5000;
  localparam int CLK_MHZ = 25;
  localparam int STEP_CYCLES = DELAY_STEP_US * CLK_MHZ;
  localparam int BLOCK_LEAD_MS = 5;
  // current in 0.1 % of nominal
  localparam logic [15:0] LIGHT_LOAD_LIMIT = 16'h000A;
  localparam logic [15:0] HIGH_OVL_LIMIT = 16'h07D0;
  // service factor, ambient k, nominal factor in 0.01 units
  localparam logic [9:0] UNITY_FACTOR = 10'h064;
  typedef enum logic [2:0] {
    COND_NORMAL = 3'b000,
    COND_ALARM1 = 3'b001,
    COND_ALARM2 = 3'b010,
    COND_INHIBIT = 3'b011,
    COND_TRIP = 3'b100,
    COND_BLOCKED = 3'b101
  } condition_t;
  typedef enum logic [2:0] {
    MODE_ON = 3'b000,
    MODE_BLOCKED = 3'b001,
    MODE_TEST = 3'b010,
    MODE_TEST_BLOCKED = 3'b011,
    MODE_OFF = 3'b100
  } mode_t;
  typedef enum logic [1:0] {
    LOAD_LIGHT = 2'b00,
    LOAD_NORMAL = 2'b01,
    LOAD_OVERLOADING = 2'b10,
    LOAD_HIGH = 2'b11
  } load_t;
endpackage

// ### logic/thermal_overload_stage.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: alarm 1 asserts when enabled and capacity reaches its level.
// RULE2: alarm 2 asserts likewise with its own independent level.
// RULE3: restart inhibit asserts when enabled and capacity reaches its level.
// RULE4: trip asserts after capacity reaches trip level plus settable delay.
// RULE5: block input is sampled once at each program cycle start.
// RULE6: pick-up while unblocked gives start and timing proceeds.
// RULE7: pick-up while blocked gives blocked, no timing, no outputs.
// RULE8: block during start clears start and resets like pick-up release.
// RULE9: blocker must assert block at least 5 ms before delay expiry.
// RULE10: settings may change while running; new set applies immediately.
// RULE11: condition code reported; when normal no output is driven. Code: condition ignores start_out and follows the other outputs one clock late.
// RULE12: behaviour mode reported only when per-node mode is allowed.
// RULE13: light load below 1 % nominal; normal load below trip limit.
// RULE14: overloading between pick-up and 2 In; high overload above 2 In.
// RULE15: invalid service factor uses 1.0 and flags a fault while present.
// RULE16: invalid ambient settings use 1.0 and flag an ambient fault.
// RULE17: invalid nominal current settings use 1.0 and flag a fault.
// RULE18: contradictory ambient k settings flag while they persist.
// RULE19: outputs drop in the cycle capacity falls below their level.
module thermal_overload_stage #(
  parameter int STEP_CYC = thermal_stage_pkg::STEP_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic cycle_tick_in,
  input wire logic [thermal_stage_pkg::CAP_W-1:0] capacity_in,
  input wire logic block_in,
  input wire logic alarm1_en_in,
  input wire logic [thermal_stage_pkg::CAP_W-1:0] alarm1_level_in,
  input wire logic alarm2_en_in,
  input wire logic [thermal_stage_pkg::CAP_W-1:0] alarm2_level_in,
  input wire logic inhibit_en_in,
  input wire logic [thermal_stage_pkg::CAP_W-1:0] inhibit_level_in,
  input wire logic trip_en_in,
  input wire logic [thermal_stage_pkg::CAP_W-1:0] trip_level_in,
  input wire logic [thermal_stage_pkg::DELAY_W-1:0] trip_delay_in,
  input wire logic [15:0] current_in,
  input wire logic [15:0] pickup_current_in,
  input wire logic [2:0] mode_in,
  input wire logic node_mode_allowed_in,
  input wire logic [9:0] service_factor_in,
  input wire logic service_factor_bad_in,
  input wire logic ambient_bad_in,
  input wire logic ambient_k_conflict_in,
  input wire logic nominal_bad_in,
  output logic alarm1_out,
  output logic alarm2_out,
  output logic inhibit_out,
  output logic trip_out,
  output logic start_out,
  output logic blocked_out,
  output thermal_stage_pkg::condition_t condition_out,
  output logic mode_valid_out,
  output thermal_stage_pkg::mode_t mode_out,
  output thermal_stage_pkg::load_t load_out,
  output logic [9:0] service_factor_out,
  output logic sf_fault_out,
  output logic ambient_fault_out,
  output logic [9:0] ambient_k_out,
  output logic nominal_fault_out,
  output logic [9:0] nominal_factor_out,
  output logic ambient_conflict_out
);
  import thermal_stage_pkg::*;

  typedef struct packed {
    logic blk_s1;
    logic blk_s2;
    logic blk_cyc;
    logic a1;
    logic a2;
    logic inh;
    logic trip;
    logic start;
    logic blocked;
    logic [DELAY_W-1:0] steps;
    logic [31:0] sub;
    condition_t cond;
    logic mvalid;
    mode_t mode;
    load_t load;
    logic [9:0] sf;
    logic sf_f;
    logic amb_f;
    logic [9:0] amb_k;
    logic nom_f;
    logic [9:0] nom_k;
    logic amb_c;
  } state_t;

  state_t st;
  state_t next_st;
  logic pick;

  function automatic logic reached(input logic [CAP_W-1:0] cap,
                                   input logic [CAP_W-1:0] lvl);
    reached = cap >= lvl;
  endfunction

  always_comb begin
    next_st = st;
    // block pin through two flops, then latched once per program cycle
    next_st.blk_s1 = block_in;
    next_st.blk_s2 = st.blk_s1;
    pick = trip_en_in && reached(capacity_in, trip_level_in);
    if (cycle_tick_in) begin
      next_st.blk_cyc = st.blk_s2; // RULE5
      // levels compared against live settings each cycle
      next_st.a1 = alarm1_en_in && // RULE10
                   reached(capacity_in, alarm1_level_in); // RULE1 RULE19
      next_st.a2 = alarm2_en_in &&
                   reached(capacity_in, alarm2_level_in); // RULE2 RULE19
      next_st.inh = inhibit_en_in &&
                    reached(capacity_in, inhibit_level_in); // RULE3 RULE19
      if (!pick) begin
        next_st.start = 1'b0;
        next_st.blocked = 1'b0;
        next_st.trip = 1'b0; // RULE19
        next_st.steps = '0;
        next_st.sub = '0;
      end else if (st.blk_s2) begin
        // blocked pick-up, or start released by a new block
        next_st.start = 1'b0; // RULE7 RULE8
        next_st.blocked = 1'b1; // RULE7
        next_st.trip = 1'b0;
        next_st.steps = '0;
        next_st.sub = '0;
      end else begin
        next_st.start = 1'b1; // RULE6
        next_st.blocked = 1'b0;
      end
      if (st.blk_s2) begin
        next_st.a1 = 1'b0;
        next_st.a2 = 1'b0;
        next_st.inh = 1'b0;
      end
    end
    // trip delay timer runs while started; a tick that drops the
    // pick-up or blocks the stage wins over the timer
    if (st.start && next_st.start && !st.trip && !st.blk_cyc) begin
      if (st.steps >= trip_delay_in) begin
        next_st.trip = 1'b1; // RULE4
      end else if (st.sub >= 32'(STEP_CYC - 1)) begin
        next_st.sub = '0;
        next_st.steps = st.steps + 1'b1;
      end else begin
        next_st.sub = st.sub + 32'h1;
      end
    end
    if (st.trip) next_st.cond = COND_TRIP; // RULE11
    else if (st.blocked) next_st.cond = COND_BLOCKED;
    else if (st.inh) next_st.cond = COND_INHIBIT;
    else if (st.a2) next_st.cond = COND_ALARM2;
    else if (st.a1) next_st.cond = COND_ALARM1;
    else next_st.cond = COND_NORMAL;
    next_st.mvalid = node_mode_allowed_in; // RULE12
    next_st.mode = node_mode_allowed_in ? mode_t'(mode_in) : MODE_ON;
    if (current_in < LIGHT_LOAD_LIMIT) next_st.load = LOAD_LIGHT; // RULE13
    else if (current_in > HIGH_OVL_LIMIT) next_st.load = LOAD_HIGH; // RULE14
    else if (current_in > pickup_current_in) next_st.load = LOAD_OVERLOADING;
    else next_st.load = LOAD_NORMAL;
    next_st.sf_f = service_factor_bad_in; // RULE15
    next_st.sf = service_factor_bad_in ? UNITY_FACTOR : service_factor_in;
    next_st.amb_f = ambient_bad_in; // RULE16
    next_st.amb_k = UNITY_FACTOR;
    next_st.nom_f = nominal_bad_in; // RULE17
    next_st.nom_k = UNITY_FACTOR;
    next_st.amb_c = ambient_k_conflict_in; // RULE18
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign alarm1_out = st.a1;
  assign alarm2_out = st.a2;
  assign inhibit_out = st.inh;
  assign trip_out = st.trip;
  assign start_out = st.start;
  assign blocked_out = st.blocked;
  assign condition_out = st.cond;
  assign mode_valid_out = st.mvalid;
  assign mode_out = st.mode;
  assign load_out = st.load;
  assign service_factor_out = st.sf;
  assign sf_fault_out = st.sf_f;
  assign ambient_fault_out = st.amb_f;
  assign ambient_k_out = st.amb_k;
  assign nominal_fault_out = st.nom_f;
  assign nominal_factor_out = st.nom_k;
  assign ambient_conflict_out = st.amb_c;

  AST_ALARM1_SET: assert property ( // RULE1 RULE10
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && alarm1_en_in && !st.blk_s2 &&
    capacity_in >= alarm1_level_in |=> alarm1_out)
    else $error("alarm 1 missed");
  AST_ALARM2_SET: assert property ( // RULE2
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && alarm2_en_in && !st.blk_s2 &&
    capacity_in >= alarm2_level_in |=> alarm2_out)
    else $error("alarm 2 missed");
  AST_INHIBIT_SET: assert property ( // RULE3
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && inhibit_en_in && !st.blk_s2 &&
    capacity_in >= inhibit_level_in |=> inhibit_out)
    else $error("inhibit missed");
  AST_TRIP_NEEDS_START: assert property ( // RULE4
    @(posedge mclk_in) disable iff (rst_in)
    $rose(trip_out) |-> $past(start_out))
    else $error("trip without start");
  AST_TRIP_DELAY: assert property ( // RULE4
    @(posedge mclk_in) disable iff (rst_in)
    $rose(trip_out) |-> $past(st.steps) >= $past(trip_delay_in))
    else $error("trip before its delay");
  AST_BLOCK_SAMPLED: assert property ( // RULE5
    @(posedge mclk_in) disable iff (rst_in)
    !cycle_tick_in |=> $stable(start_out) && $stable(blocked_out))
    else $error("block acted between ticks");
  AST_BLOCK_NO_TRIP: assert property ( // RULE7
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && st.blk_s2 |=> !trip_out && !start_out)
    else $error("blocked stage operated");
  AST_BLOCK_RELEASE: assert property ( // RULE8
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && pick && st.blk_s2 && start_out |=>
    !start_out && blocked_out)
    else $error("start not released by block");
  AST_START_SET: assert property ( // RULE6
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && pick && !st.blk_s2 |=> start_out)
    else $error("start missed");
  AST_DROP_CLEARS: assert property ( // RULE19
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && !pick |=> !trip_out && !start_out)
    else $error("trip held below its level");
  AST_NORMAL_QUIET: assert property ( // RULE11
    @(posedge mclk_in) disable iff (rst_in)
    !trip_out && !blocked_out && !inhibit_out && !alarm1_out &&
    !alarm2_out |=> condition_out == COND_NORMAL)
    else $error("condition not normal");
  AST_ALARM_DROP: assert property ( // RULE19
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && capacity_in < alarm1_level_in |=> !alarm1_out)
    else $error("alarm 1 held");
  AST_ALARM2_DROP: assert property ( // RULE19
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && capacity_in < alarm2_level_in |=> !alarm2_out)
    else $error("alarm 2 held");
  AST_INHIBIT_DROP: assert property ( // RULE19
    @(posedge mclk_in) disable iff (rst_in)
    cycle_tick_in && capacity_in < inhibit_level_in |=> !inhibit_out)
    else $error("inhibit held");
  AST_MODE_HIDDEN: assert property ( // RULE12
    @(posedge mclk_in) disable iff (rst_in)
    !node_mode_allowed_in |=> !mode_valid_out && mode_out == MODE_ON)
    else $error("mode shown while not allowed");
  AST_MODE_SHOWN: assert property ( // RULE12
    @(posedge mclk_in) disable iff (rst_in)
    node_mode_allowed_in |=> mode_valid_out && mode_out == $past(mode_in))
    else $error("mode not shown");
  AST_LIGHT: assert property ( // RULE13
    @(posedge mclk_in) disable iff (rst_in)
    current_in < LIGHT_LOAD_LIMIT |=> load_out == LOAD_LIGHT)
    else $error("light load missed");
  AST_NORMAL_LOAD: assert property ( // RULE13
    @(posedge mclk_in) disable iff (rst_in)
    current_in >= LIGHT_LOAD_LIMIT && current_in <= HIGH_OVL_LIMIT &&
    current_in <= pickup_current_in |=> load_out == LOAD_NORMAL)
    else $error("normal load missed");
  AST_OVERLOADING: assert property ( // RULE14
    @(posedge mclk_in) disable iff (rst_in)
    current_in >= LIGHT_LOAD_LIMIT && current_in <= HIGH_OVL_LIMIT &&
    current_in > pickup_current_in |=> load_out == LOAD_OVERLOADING)
    else $error("overloading missed");
  AST_HIGH_OVL: assert property ( // RULE14
    @(posedge mclk_in) disable iff (rst_in)
    current_in > HIGH_OVL_LIMIT |=> load_out == LOAD_HIGH)
    else $error("high overload missed");
  AST_SF_OVERRIDE: assert property ( // RULE15
    @(posedge mclk_in) disable iff (rst_in)
    service_factor_bad_in |=> sf_fault_out &&
    service_factor_out == UNITY_FACTOR)
    else $error("service factor not overridden");
  AST_SF_CLEAR: assert property ( // RULE15
    @(posedge mclk_in) disable iff (rst_in)
    !service_factor_bad_in |=> !sf_fault_out &&
    service_factor_out == $past(service_factor_in))
    else $error("service factor fault shown without cause");
  AST_AMB_OVERRIDE: assert property ( // RULE16
    @(posedge mclk_in) disable iff (rst_in)
    ambient_bad_in |=> ambient_fault_out &&
    ambient_k_out == UNITY_FACTOR)
    else $error("ambient factor not overridden");
  AST_NOM_OVERRIDE: assert property ( // RULE17
    @(posedge mclk_in) disable iff (rst_in)
    nominal_bad_in |=> nominal_fault_out &&
    nominal_factor_out == UNITY_FACTOR)
    else $error("nominal factor not overridden");
  AST_AMB_CONFLICT: assert property ( // RULE18
    @(posedge mclk_in) disable iff (rst_in)
    1'b1 |=> ambient_conflict_out == $past(ambient_k_conflict_in))
    else $error("ambient conflict flag wrong");
  COV_TRIP: cover property (@(posedge mclk_in) disable iff (rst_in)
    $rose(trip_out));
  COV_BLOCKED: cover property (@(posedge mclk_in) disable iff (rst_in)
    $rose(blocked_out));
  COV_RELEASE: cover property (@(posedge mclk_in) disable iff (rst_in)
    start_out ##1 blocked_out);
  COV_ALARM1: cover property (@(posedge mclk_in) disable iff (rst_in)
    $rose(alarm1_out));
  COV_INHIBIT: cover property (@(posedge mclk_in) disable iff (rst_in)
    $rose(inhibit_out));
endmodule // thermal_overload_stage

// ### test/thermal_far_side.sv
`timescale 1ns/1ps
module thermal_far_side #(
  parameter int TICK_DIV = 4
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic block_req_in,
  output logic cycle_tick_out,
  output logic block_out
);
  logic [7:0] div;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      div <= 8'h00;
      cycle_tick_out <= 1'b0;
      block_out <= 1'b0;
    end else begin
      div <= (div == 8'(TICK_DIV - 1)) ? 8'h00 : div + 8'h01;
      cycle_tick_out <= (div == 8'h00);
      // bench raises block only 5 clocks before the 2-step trip delay expires
      block_out <= block_req_in;
    end
  end
endmodule // thermal_far_side

// ### test/test_thermal_overload_stage.sv
`timescale 1ns/1ps
module test_thermal_overload_stage;
  import thermal_stage_pkg::*;
  `define CHK(g, e) chk((g) === (e), `__LINE__)
  logic mclk_in = 1'b0, rst_in = 1'b1, cycle_tick_in, block_in;
  logic block_req = 1'b0, trip_en_in = 1'b1, node_mode_allowed_in = 1'b1;
  logic alarm1_en_in = 1'b1, alarm2_en_in = 1'b1, inhibit_en_in = 1'b1;
  logic service_factor_bad_in = 1'b0, ambient_bad_in = 1'b0;
  logic nominal_bad_in = 1'b0, ambient_k_conflict_in = 1'b0;
  logic [10:0] capacity_in = 11'h000, alarm1_level_in = 11'h12C;
  logic [10:0] alarm2_level_in = 11'h1F4, inhibit_level_in = 11'h2BC;
  logic [10:0] trip_level_in = 11'h3E8;
  logic [19:0] trip_delay_in = 20'h00000;
  logic [15:0] current_in = 16'h0005, pickup_current_in = 16'h041A;
  logic [2:0] mode_in = 3'h2;
  logic [9:0] service_factor_in = 10'h078;
  logic alarm1_out, alarm2_out, inhibit_out, trip_out, start_out;
  logic blocked_out, mode_valid_out, sf_fault_out, ambient_fault_out;
  logic nominal_fault_out, ambient_conflict_out;
  condition_t condition_out;
  mode_t mode_out;
  load_t load_out;
  logic [9:0] service_factor_out, ambient_k_out, nominal_factor_out;
  int mismatches = 0, cmp_count = 0;
  logic [10:0] caps [7] = '{11'h12B, 11'h12C, 11'h1F3, 11'h1F4,
    11'h2BB, 11'h2BC, 11'h3E7};
  logic [15:0] curs [4] = '{16'h0005, 16'h01F4, 16'h05DC, 16'h09C4};
  load_t loads [4] = '{LOAD_LIGHT, LOAD_NORMAL, LOAD_OVERLOADING, LOAD_HIGH};
  condition_t conds [7] = '{COND_NORMAL, COND_ALARM1, COND_ALARM1,
    COND_ALARM2, COND_ALARM2, COND_INHIBIT, COND_INHIBIT};

  thermal_far_side #(.TICK_DIV(4)) far (.mclk_in, .rst_in,
    .block_req_in(block_req), .cycle_tick_out(cycle_tick_in),
    .block_out(block_in));
  thermal_overload_stage #(.STEP_CYC(4)) DUT (.mclk_in, .rst_in,
    .cycle_tick_in, .capacity_in, .block_in, .alarm1_en_in,
    .alarm1_level_in, .alarm2_en_in, .alarm2_level_in, .inhibit_en_in,
    .inhibit_level_in, .trip_en_in, .trip_level_in, .trip_delay_in,
    .current_in, .pickup_current_in, .mode_in, .node_mode_allowed_in,
    .service_factor_in, .service_factor_bad_in, .ambient_bad_in,
    .ambient_k_conflict_in, .nominal_bad_in, .alarm1_out, .alarm2_out,
    .inhibit_out, .trip_out, .start_out, .blocked_out, .condition_out,
    .mode_valid_out, .mode_out, .load_out, .service_factor_out,
    .sf_fault_out, .ambient_fault_out, .ambient_k_out, .nominal_fault_out,
    .nominal_factor_out, .ambient_conflict_out);

  always #20 mclk_in = ~mclk_in;

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic chk(input logic ok, input int ln);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: compare failed, line %0d", $time, ln);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #2000000;
    mismatches++;
    results();
  end

  initial begin
    wt(8);
    rst_in <= 1'b0;
    foreach (caps[i]) begin
      capacity_in <= caps[i];
      wt(12);
      `CHK(alarm1_out, caps[i] >= alarm1_level_in);
      `CHK(alarm2_out, caps[i] >= alarm2_level_in);
      `CHK(inhibit_out, caps[i] >= inhibit_level_in);
      `CHK(trip_out, 1'b0);
      `CHK(condition_out, conds[i]);
    end
    capacity_in <= 11'h12B;
    wt(12);
    `CHK(condition_out, COND_NORMAL);
    capacity_in <= 11'h3E8;
    wt(12);
    `CHK({start_out, trip_out}, 2'b11);
    `CHK(condition_out, COND_TRIP);
    alarm1_level_in <= 11'h3F2;
    wt(12);
    `CHK(alarm1_out, 1'b0);
    $display("thresholds done");
    capacity_in <= 11'h000;
    trip_delay_in <= 20'h00002;
    wt(12);
    capacity_in <= 11'h3E8;
    wt(6);
    `CHK({start_out, trip_out}, 2'b10);
    block_req <= 1'b1;
    wt(60);
    `CHK({start_out, blocked_out, trip_out}, 3'b010);
    `CHK(condition_out, COND_BLOCKED);
    block_req <= 1'b0;
    wt(60);
    `CHK(trip_out, 1'b1);
    capacity_in <= 11'h000;
    block_req <= 1'b1;
    wt(12);
    capacity_in <= 11'h3E8;
    wt(60);
    `CHK({start_out, blocked_out, trip_out}, 3'b010);
    block_req <= 1'b0;
    $display("blocking done");
    foreach (curs[i]) begin
      current_in <= curs[i];
      wt(3);
      `CHK(load_out, loads[i]);
    end
    `CHK({mode_valid_out, mode_out}, {1'b1, MODE_TEST});
    node_mode_allowed_in <= 1'b0;
    wt(3);
    `CHK({mode_valid_out, mode_out}, {1'b0, MODE_ON});
    {service_factor_bad_in, ambient_bad_in} <= 2'b11;
    {nominal_bad_in, ambient_k_conflict_in} <= 2'b11;
    wt(3);
    `CHK({sf_fault_out, service_factor_out}, {1'b1, UNITY_FACTOR});
    `CHK({ambient_fault_out, ambient_k_out}, {1'b1, UNITY_FACTOR});
    `CHK(nominal_fault_out, 1'b1);
    `CHK(nominal_factor_out, UNITY_FACTOR);
    `CHK(ambient_conflict_out, 1'b1);
    {service_factor_bad_in, ambient_bad_in} <= 2'b00;
    {nominal_bad_in, ambient_k_conflict_in} <= 2'b00;
    wt(3);
    `CHK({sf_fault_out, service_factor_out}, {1'b0, 10'h078});
    `CHK({ambient_fault_out, nominal_fault_out}, 2'b00);
    `CHK(ambient_conflict_out, 1'b0);
    $display("status done");
    {alarm2_en_in, trip_en_in} <= 2'b00;
    capacity_in <= 11'h5DC;
    wt(12);
    `CHK({alarm1_out, alarm2_out, inhibit_out}, 3'b101);
    `CHK({start_out, trip_out}, 2'b00);
    `CHK(condition_out, COND_INHIBIT);
    $display("enables done");
    results();
  end
endmodule // test_thermal_overload_stage
